// ===== bench/smrbm_mem_model.sv
/*
 * Asynchronous memory on the far side of the read pins.
 * Assumes the master clock of the controller; drives the addressed word only while selected.
 */
`default_nettype none
module smrbm_mem_model
    import smrbm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:2] addr_out,
    input  wire logic [NUM_CS-1:0] chip_select_n,
    output logic      [DATA_W-1:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0]      stale = 32'h00000000;
    wire  logic [DATA_W-1:0] word = {8'hC3, 18'h00000, addr_out[7:2]};
    wire  logic              selected = (chip_select_n != 8'hFF);
    // a released bus shows the inverse of its last value
    always_ff @(posedge clk) begin
        stale <= ~data_in;
    end
    assign data_in = selected ? word : stale;
endmodule
`default_nettype wire

// ===== bench/static_memory_read_and_bus_mapping_test.sv
/*
 * Self-checking bench for the read waveform and shared pin mapping.
 * Assumes the memory model answers whenever a chip select is low.
 */
`default_nettype none
module static_memory_read_and_bus_mapping_test
    import smrbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset_n = 0, req_valid = 0, boot_active = 0;
    logic [2:0]                req_cs = 3'h0;
    logic [ADDR_W-1:0]         req_addr = 26'h0000000;
    logic [3:0]                req_be = 4'h0;
    logic [NUM_CS*2-1:0]       cfg_dbw = '0;
    logic [NUM_CS-1:0]         cfg_bat = '0, cfg_mode = '0;
    logic [NUM_CS*SETUP_W-1:0] cfg_rs = '0, cfg_css = '0;
    logic [NUM_CS*PULSE_W-1:0] cfg_rp = '0, cfg_csp = '0;
    logic [NUM_CS*CYCLE_W-1:0] cfg_cy = '0;
    wire  logic [DATA_W-1:0]   data_in;
    logic req_ready, rd_valid, pin0, pin1, pin2, pin3, write_enable_n, read_strobe_n;
    logic [DATA_W-1:0]   rd_data;
    logic [ADDR_W-1:2]   addr_out;
    logic [NUM_CS-1:0]   chip_select_n;
    int fails = 0, checks_done = 0;
    // master clock, 4 ns period
    always #2 clk = ~clk;
    smrbm_read_ctrl u_smrbm_read_ctrl (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
        .req_cs(req_cs), .req_addr(req_addr), .req_be(req_be), .boot_active(boot_active),
        .cfg_data_bus_width(cfg_dbw), .cfg_byte_access_type(cfg_bat), .cfg_read_mode(cfg_mode),
        .cfg_read_strobe_setup(cfg_rs), .cfg_read_strobe_pulse(cfg_rp),
        .cfg_chip_select_read_setup(cfg_css), .cfg_chip_select_read_pulse(cfg_csp),
        .cfg_read_cycle_length(cfg_cy), .data_in(data_in), .req_ready(req_ready),
        .rd_data(rd_data), .rd_valid(rd_valid), .addr_out(addr_out),
        .pin0_byte_select_or_addr0(pin0), .pin1_select_or_write1(pin1),
        .pin2_select_write_or_addr1(pin2), .pin3_select_or_write3(pin3),
        .write_enable_n(write_enable_n), .read_strobe_n(read_strobe_n),
        .chip_select_n(chip_select_n));
    smrbm_mem_model u_smrbm_mem_model (.clk(clk), .addr_out(addr_out),
        .chip_select_n(chip_select_n), .data_in(data_in));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        if (fails == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // effective count of a coded timing field
    function automatic int dec(input logic [8:0] c, input int lo_w, input int mul);
        return mul * int'(c >> lo_w) + int'(c & ((9'h001 << lo_w) - 9'h001));
    endfunction
    task automatic set_cfg(input int i, input logic [1:0] w, input logic byte_access_type, input logic m,
        input logic [5:0] rs, input logic [6:0] rp, input logic [5:0] css,
        input logic [6:0] csp, input logic [8:0] cy);
        cfg_dbw[2*i+:2] = w;
        cfg_bat[i] = byte_access_type;
        cfg_mode[i] = m;
        cfg_rs[6*i+:6] = rs;
        cfg_rp[7*i+:7] = rp;
        cfg_css[6*i+:6] = css;
        cfg_csp[7*i+:7] = csp;
        cfg_cy[9*i+:9] = cy;
    endtask
    // one read, judging pins, waveform, capture moment and data
    task automatic do_read(input int cs, input logic [ADDR_W-1:0] a, input logic [3:0] be);
        int s, p, cs_s, cs_p, c, lat, n, rd_low, cs_low, seen;
        logic [1:0] w;
        logic byte_access_type, e0, e1, e2, e3;
        s = dec(9'(cfg_rs[6*cs+:6]), 5, 128);
        p = dec(9'(cfg_rp[7*cs+:7]), 6, 256);
        cs_s = dec(9'(cfg_css[6*cs+:6]), 5, 128);
        cs_p = dec(9'(cfg_csp[7*cs+:7]), 6, 256);
        c = dec(cfg_cy[9*cs+:9], 7, 256);
        w = cfg_dbw[2*cs+:2];
        byte_access_type = cfg_bat[cs] & ~(boot_active & (cs == 0));
        lat = (cfg_mode[cs] == MODE_BY_RD) ? s + p + 1 : cs_s + cs_p + 1;
        e0 = (w == WIDTH_8) ? a[0] : (byte_access_type == BAT_SELECT) ? ~be[0] : 1'b1;
        e1 = (w != WIDTH_8 && byte_access_type == BAT_SELECT) ? ~be[1] : 1'b1;
        e2 = (w != WIDTH_32) ? a[1] : (byte_access_type == BAT_SELECT) ? ~be[2] : 1'b1;
        e3 = (w == WIDTH_32 && byte_access_type == BAT_SELECT) ? ~be[3] : 1'b1;
        req_cs = 3'(cs);
        req_addr = a;
        req_be = be;
        req_valid = 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        req_valid = 1'b0;
        rd_low = 0;
        cs_low = 0;
        seen = 0;
        check("address", 32'(addr_out), 32'(a[ADDR_W-1:2]));
        check("select pins", {pin3, pin1}, {e3, e1});
        check("shared pins", {pin2, pin0, write_enable_n}, {e2, e0, 1'b1});
        check("strobe at address", read_strobe_n, s != 0);
        for (n = 1; n <= c + 1; n++) begin
            if (n <= c && read_strobe_n === 1'b0) rd_low++;
            if (n <= c && chip_select_n === ~(8'h01 << cs)) cs_low++;
            if (rd_valid === 1'b1 && seen == 0) begin
                seen = n;
                check("read data", rd_data, {8'hC3, 18'h00000, a[7:2]});
            end
            if (n <= c) @(negedge clk);
        end
        // idle cycle after the read: selects and chip selects released
        check("idle selects", {pin3, pin1, chip_select_n}, {2'b11, CS_N_RESET});
        check("idle shared", {pin2, pin0}, {e2 | (w == WIDTH_32), e0 | (w != WIDTH_8)});
        check("strobe low cycles", rd_low, p);
        check("select low cycles", cs_low, cs_p);
        check("capture moment", seen, lat);
    endtask
    // pin map per width and access type, each select with its own timing
    // every pulse kept at least one
    task automatic pin_table;
        set_cfg(1, WIDTH_32, BAT_SELECT, MODE_BY_RD, 6'h01, 7'h01, 6'h00, 7'h02, 9'h003);
        do_read(1, 26'h0000104, 4'h5);
        set_cfg(2, WIDTH_32, BAT_WRITE, MODE_BY_RD, 6'h01, 7'h02, 6'h01, 7'h02, 9'h004);
        do_read(2, 26'h2000108, 4'hA);
        set_cfg(3, WIDTH_16, BAT_SELECT, MODE_BY_RD, 6'h02, 7'h01, 6'h00, 7'h03, 9'h003);
        do_read(3, 26'h000020E, 4'h2);
        set_cfg(4, WIDTH_16, BAT_WRITE, MODE_BY_RD, 6'h00, 7'h02, 6'h01, 7'h02, 9'h005);
        do_read(4, 26'h0000302, 4'h3);
        set_cfg(6, WIDTH_8, BAT_SELECT, MODE_BY_RD, 6'h01, 7'h01, 6'h01, 7'h01, 9'h002);
        do_read(6, 26'h1000006, 4'h0);
    endtask
    // chip select governs capture, strobe rises earlier
    task automatic capture_by_select;
        set_cfg(7, WIDTH_8, BAT_SELECT, MODE_BY_CS, 6'h00, 7'h02, 6'h01, 7'h02, 9'h004);
        do_read(7, 26'h3FFFFC5, 4'h0);
    endtask
    // upper code bits carry their weights
    task automatic coded_counts;
        set_cfg(0, WIDTH_32, BAT_SELECT, MODE_BY_RD, 6'h21, 7'h41, 6'h20, 7'h42, 9'h181);
        do_read(0, 26'h0000010, 4'hF);
    endtask
    // boot forces select access on select zero
    task automatic boot_access;
        set_cfg(0, WIDTH_32, BAT_WRITE, MODE_BY_RD, 6'h01, 7'h01, 6'h00, 7'h02, 9'h003);
        boot_active = 1'b1;
        do_read(0, 26'h0000400, 4'h6);
        boot_active = 1'b0;
        do_read(0, 26'h0000400, 4'h6);
    endtask
    // zero setup and hold keep both signals low across two reads
    task automatic back_to_back;
        int n, takes, lows, valids;
        set_cfg(5, WIDTH_16, BAT_SELECT, MODE_BY_RD, 6'h00, 7'h03, 6'h00, 7'h03, 9'h003);
        req_cs = 3'h5;
        req_addr = 26'h0000010;
        req_be = 4'hF;
        req_valid = 1'b1;
        takes = 0;
        lows = 0;
        valids = 0;
        for (n = 0; n < 9; n++) begin
            if (req_ready === 1'b1 && req_valid === 1'b1) takes++;
            @(negedge clk);
            if (takes == 2) req_valid = 1'b0;
            if (n <= 5 && read_strobe_n === 1'b0 && chip_select_n === 8'hDF) lows++;
            if (rd_valid === 1'b1) valids++;
        end
        check("seamless takes", takes, 2);
        check("seamless low cycles", lows, 6);
        check("seamless captures", valids, 2);
    endtask
    // watchdog against a hang
    initial begin
        #40000;
        fails++;
        conclude();
    end
    initial begin
        repeat (10) @(negedge clk);
        check("reset outputs", {req_ready, rd_valid, read_strobe_n, chip_select_n},
              {1'b1, 1'b0, 1'b1, CS_N_RESET});
        reset_n = 1'b1;
        @(negedge clk);
        pin_table();
        capture_by_select();
        coded_counts();
        boot_access();
        back_to_back();
        conclude();
    end
endmodule
`default_nettype wire

// ===== hdl/smrbm_pkg.sv
/*
 * Constants for the static memory read path and pin mapping.
 * Assumes a single master clock; configuration fields arrive as plain ports.
 */
`default_nettype none
package smrbm_pkg;
    localparam int          NUM_CS       = 8;
    localparam int          ADDR_W       = 26;
    localparam int          DATA_W       = 32;
    localparam int          CNT_W        = 10;
    localparam int          SETUP_W      = 6;
    localparam int          PULSE_W      = 7;
    localparam int          CYCLE_W      = 9;
    // data bus width codes
    localparam logic [1:0]  WIDTH_8      = 2'h0;
    localparam logic [1:0]  WIDTH_16     = 2'h1;
    localparam logic [1:0]  WIDTH_32     = 2'h2;
    // byte access type codes
    localparam logic        BAT_SELECT   = 1'b0;
    localparam logic        BAT_WRITE    = 1'b1;
    // read mode codes
    localparam logic        MODE_BY_CS   = 1'b0;
    localparam logic        MODE_BY_RD   = 1'b1;
    // weights of the upper code bits
    localparam logic [9:0]  SETUP_HI_MUL = 10'h080;
    localparam logic [9:0]  PULSE_HI_MUL = 10'h100;
    localparam logic [9:0]  CYCLE_HI_MUL = 10'h100;
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
    // reset values of pins and read data
    localparam logic [7:0]  CS_N_RESET   = 8'hFF;
    localparam logic [23:0] ADDR_RESET   = 24'h000000;
    localparam logic [31:0] DATA_RESET   = 32'h00000000;
    typedef enum logic [1:0] {
        SMRBM_IDLE = 2'h1,
        SMRBM_READ = 2'h2
    } smrbm_state_t;
endpackage
`default_nettype wire

// ===== hdl/smrbm_read_ctrl.sv
/*
 * Read waveform generator and shared pin mapping for eight chip selects.
 * Assumes the master holds req_* stable while req_valid is high and not taken,
 * and that software keeps each pulse at least one cycle and setup+pulse <= cycle.
 */
// How it works
// - drive 26 address lines per chip select
// - upper address passes through, small devices wrap
// - address bit range depends on bus width
// - per chip select 8, 16, 32 width
// - access type picks byte write or select
// - byte write: per byte strobes, one read
// - no byte write access on chip select zero while booting
// - byte select: per byte selects, one read
// - unused address bits and strobes stay idle
// - shared pins switch by width and type
// - byte selects timed like the address
// - byte strobes timed like write enable
// - read cycle starts by presenting address
// - strobe falls after setup, lasts pulse
// - chip select has own setup and pulse
// - hold is cycle minus setup minus pulse
// - timings per chip select, whole cycles
// - zero setup and hold stay asserted on the same chip select
// - read mode picks capture signal, no compare
// - mode 1 captures at strobe rise edge
// - mode 0 captures at select rise edge
// - setup code is 128*b5 plus low bits
// - pulse code is 256*b6 plus low bits
// - cycle code is 256*b8:7 plus low bits
`default_nettype none
module smrbm_read_ctrl
    import smrbm_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic                      req_valid,
    input  wire logic [2:0]                req_cs,
    input  wire logic [ADDR_W-1:0]         req_addr,
    input  wire logic [3:0]                req_be,
    input  wire logic                      boot_active,
    input  wire logic [NUM_CS*2-1:0]       cfg_data_bus_width,
    input  wire logic [NUM_CS-1:0]         cfg_byte_access_type,
    input  wire logic [NUM_CS-1:0]         cfg_read_mode,
    input  wire logic [NUM_CS*SETUP_W-1:0] cfg_read_strobe_setup,
    input  wire logic [NUM_CS*PULSE_W-1:0] cfg_read_strobe_pulse,
    input  wire logic [NUM_CS*SETUP_W-1:0] cfg_chip_select_read_setup,
    input  wire logic [NUM_CS*PULSE_W-1:0] cfg_chip_select_read_pulse,
    input  wire logic [NUM_CS*CYCLE_W-1:0] cfg_read_cycle_length,
    input  wire logic [DATA_W-1:0]         data_in,
    output logic                           req_ready,
    output logic [DATA_W-1:0]              rd_data,
    output logic                           rd_valid,
    output logic [ADDR_W-1:2]              addr_out,
    output logic                           pin0_byte_select_or_addr0,
    output logic                           pin1_select_or_write1,
    output logic                           pin2_select_write_or_addr1,
    output logic                           pin3_select_or_write3,
    output logic                           write_enable_n,
    output logic                           read_strobe_n,
    output logic [NUM_CS-1:0]              chip_select_n
);
    logic [1:0]         width_of [NUM_CS];
    logic               bat_of   [NUM_CS];
    logic [SETUP_W-1:0] rds_of   [NUM_CS];
    logic [PULSE_W-1:0] rdp_of   [NUM_CS];
    logic [SETUP_W-1:0] css_of   [NUM_CS];
    logic [PULSE_W-1:0] csp_of   [NUM_CS];
    logic [CYCLE_W-1:0] cyc_of   [NUM_CS];

    for (genvar i = 0; i < NUM_CS; i++) begin : g_cfg
        assign width_of[i] = cfg_data_bus_width[i*2 +: 2];
        assign bat_of[i]   = cfg_byte_access_type[i];
        assign rds_of[i]   = cfg_read_strobe_setup[i*SETUP_W +: SETUP_W];
        assign rdp_of[i]   = cfg_read_strobe_pulse[i*PULSE_W +: PULSE_W];
        assign css_of[i]   = cfg_chip_select_read_setup[i*SETUP_W +: SETUP_W];
        assign csp_of[i]   = cfg_chip_select_read_pulse[i*PULSE_W +: PULSE_W];
        assign cyc_of[i]   = cfg_read_cycle_length[i*CYCLE_W +: CYCLE_W];
    end

    smrbm_state_t     state;
    smrbm_state_t     next_state;
    logic [2:0]       cur_cs;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [2:0]       sel_cs;
    logic [CNT_W-1:0] rd_setup;
    logic [CNT_W-1:0] rd_pulse;
    logic [CNT_W-1:0] cs_setup;
    logic [CNT_W-1:0] cs_pulse;
    logic [CNT_W-1:0] cycle;

    // handshake and cycle position
    wire in_read    = (state == SMRBM_READ);
    wire take       = req_valid && req_ready && (!in_read || req_cs == cur_cs);
    wire end_now    = in_read && (cnt == cycle - CNT_ONE);
    assign sel_cs   = take ? req_cs : cur_cs;

    smrbm_timing_decode u_decode (
        .rd_setup_code (rds_of[sel_cs]),
        .rd_pulse_code (rdp_of[sel_cs]),
        .cs_setup_code (css_of[sel_cs]),
        .cs_pulse_code (csp_of[sel_cs]),
        .cycle_code    (cyc_of[sel_cs]),
        .rd_setup      (rd_setup),
        .rd_pulse      (rd_pulse),
        .cs_setup      (cs_setup),
        .cs_pulse      (cs_pulse),
        .cycle         (cycle)
    );

    // same chip select may restart on the last cycle with no gap
    assign next_state = (take || (in_read && !end_now)) ? SMRBM_READ : SMRBM_IDLE;
    assign next_cnt   = take ? '0 : (in_read ? cnt + CNT_ONE : '0);
    wire   next_read  = (next_state == SMRBM_READ);
    wire   next_ready = !next_read || (next_cnt == cycle - CNT_ONE);

    // read strobe window, hold is what remains of the cycle
    wire rd_win      = next_read && (next_cnt >= rd_setup) && (next_cnt < rd_setup + rd_pulse);
    // chip select window independent of the strobe
    wire cs_win      = next_read && (next_cnt >= cs_setup) && (next_cnt < cs_setup + cs_pulse);
    wire [NUM_CS-1:0] next_cs_n = cs_win ? ~(NUM_CS'(1) << sel_cs) : CS_N_RESET;

    // width and access type of the requested chip select
    wire [1:0] req_width = width_of[req_cs];
    // chip select zero runs no byte write access while boot_active is high
    wire       req_bat   = (boot_active && req_cs == 3'h0) ? BAT_SELECT : bat_of[req_cs];
    wire       req_w8    = (req_width == WIDTH_8);
    wire       req_w32   = (req_width == WIDTH_32);
    // width of the running chip select, for releasing the pins
    wire       cur_w8    = (width_of[cur_cs] == WIDTH_8);
    wire       cur_w32   = (width_of[cur_cs] == WIDTH_32);
    // byte select lines active only in byte select access
    wire       use_bs    = !req_w8 && (req_bat == BAT_SELECT);

    // shared pin functions for the new request
    wire map_pin0 = req_w8 ? req_addr[0] : (use_bs ? !req_be[0] : 1'b1);
    // byte select lines 1..3 follow the byte enables
    wire map_pin1 = use_bs ? !req_be[1] : 1'b1;
    wire map_pin2 = req_w32 ? (use_bs ? !req_be[2] : 1'b1) : req_addr[1];
    // line 3 unused below 32 bits
    wire map_pin3 = (req_w32 && use_bs) ? !req_be[3] : 1'b1;

    // capture edge chosen by read mode only
    wire rd_edge = in_read && (cnt == rd_setup + rd_pulse - CNT_ONE);
    wire cs_edge = in_read && (cnt == cs_setup + cs_pulse - CNT_ONE);
    wire capture = (cfg_read_mode[cur_cs] == MODE_BY_RD) ? rd_edge : cs_edge;

    // sequencing registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state     <= SMRBM_IDLE;
            cnt       <= '0;
            cur_cs    <= 3'h0;
            req_ready <= 1'b1;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            cur_cs    <= sel_cs;
            req_ready <= next_ready;
        end
    end

    // address and byte selects load at start
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_out                   <= ADDR_RESET;
            pin0_byte_select_or_addr0  <= 1'b1;
            pin1_select_or_write1      <= 1'b1;
            pin2_select_write_or_addr1 <= 1'b1;
            pin3_select_or_write3      <= 1'b1;
        end else if (take) begin
            // full address passed through, device ignores upper bits
            addr_out                   <= req_addr[ADDR_W-1:2];
            pin0_byte_select_or_addr0  <= map_pin0;
            pin1_select_or_write1      <= map_pin1;
            pin2_select_write_or_addr1 <= map_pin2;
            pin3_select_or_write3      <= map_pin3;
        end else if (!next_read) begin
            // selects released with the address cycle
            pin0_byte_select_or_addr0  <= cur_w8 ? pin0_byte_select_or_addr0 : 1'b1;
            pin1_select_or_write1      <= 1'b1;
            pin2_select_write_or_addr1 <= cur_w32 ? 1'b1 : pin2_select_write_or_addr1;
            pin3_select_or_write3      <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            read_strobe_n  <= 1'b1;
            chip_select_n  <= CS_N_RESET;
            write_enable_n <= 1'b1;
        end else begin
            read_strobe_n  <= !rd_win;
            chip_select_n  <= next_cs_n;
            // write enable and byte strobes idle in reads
            write_enable_n <= 1'b1;
        end
    end

    // read data sampled on the releasing edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data  <= DATA_RESET;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= capture;
            if (capture) begin
                rd_data <= data_in;
            end
        end
    end

    wire cs_any = !(&chip_select_n);

    property p_addr_stable;
        @(posedge clk) disable iff (!reset_n) (in_read && cnt != '0) |-> $stable(addr_out);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved in cycle");

    property p_bs_stable;
        @(posedge clk) disable iff (!reset_n) (in_read && cnt != '0) |->
            ($stable(pin0_byte_select_or_addr0) && $stable(pin1_select_or_write1) &&
             $stable(pin2_select_write_or_addr1) && $stable(pin3_select_or_write3));
    endproperty
    a_bs_stable: assert property (p_bs_stable) else $error("byte select moved in cycle");

    property p_rd_fall;
        @(posedge clk) disable iff (!reset_n) $fell(read_strobe_n) |-> (cnt == rd_setup);
    endproperty
    a_rd_fall: assert property (p_rd_fall) else $error("strobe fell at wrong count");

    property p_rd_rise;
        @(posedge clk) disable iff (!reset_n)
            ($rose(read_strobe_n) && in_read && cnt != '0) |-> (cnt == rd_setup + rd_pulse);
    endproperty
    a_rd_rise: assert property (p_rd_rise) else $error("strobe pulse length wrong");

    property p_cs_fall;
        @(posedge clk) disable iff (!reset_n) $rose(cs_any) |-> (cnt == cs_setup);
    endproperty
    a_cs_fall: assert property (p_cs_fall) else $error("chip select fell at wrong count");

    property p_cs_rise;
        @(posedge clk) disable iff (!reset_n)
            ($fell(cs_any) && in_read && cnt != '0) |-> (cnt == cs_setup + cs_pulse);
    endproperty
    a_cs_rise: assert property (p_cs_rise) else $error("select pulse length wrong");

    property p_one_cs;
        @(posedge clk) disable iff (!reset_n) $onehot0(~chip_select_n) && (cs_any -> in_read);
    endproperty
    a_one_cs: assert property (p_one_cs) else $error("bad chip select pattern");

    property p_cap_rd;
        @(posedge clk) disable iff (!reset_n)
            (rd_edge && cfg_read_mode[cur_cs] == MODE_BY_RD)
            |=> (rd_valid && rd_data == $past(data_in));
    endproperty
    a_cap_rd: assert property (p_cap_rd) else $error("strobe mode capture missed");

    property p_cap_cs;
        @(posedge clk) disable iff (!reset_n)
            (cs_edge && cfg_read_mode[cur_cs] == MODE_BY_CS)
            |=> (rd_valid && rd_data == $past(data_in));
    endproperty
    a_cap_cs: assert property (p_cap_cs) else $error("select mode capture missed");

    property p_addr0;
        @(posedge clk) disable iff (!reset_n)
            (take && req_w8) |=> (pin0_byte_select_or_addr0 == $past(req_addr[0]));
    endproperty
    a_addr0: assert property (p_addr0) else $error("pin0 not address bit 0");

    property p_bw_idle;
        @(posedge clk) disable iff (!reset_n)
            (take && !req_w8 && req_bat == BAT_WRITE)
            |=> (pin0_byte_select_or_addr0 && pin1_select_or_write1 && pin3_select_or_write3);
    endproperty
    a_bw_idle: assert property (p_bw_idle) else $error("byte write read drove selects");

    property p_boot;
        @(posedge clk) disable iff (!reset_n)
            (take && boot_active && req_cs == 3'h0 && !req_w8)
            |=> (pin1_select_or_write1 == !$past(req_be[1]));
    endproperty
    a_boot: assert property (p_boot) else $error("boot used byte write access");

    property p_b2b;
        @(posedge clk) disable iff (!reset_n)
            (end_now && take && !read_strobe_n && rd_setup == '0) |=> !read_strobe_n;
    endproperty
    a_b2b: assert property (p_b2b) else $error("strobe dropped between reads");

    c_cap_rd: cover property (@(posedge clk) disable iff (!reset_n) rd_edge && capture);
    c_cap_cs: cover property (@(posedge clk) disable iff (!reset_n) cs_edge && capture);
    c_b2b:    cover property (@(posedge clk) disable iff (!reset_n) end_now && take);
    c_w8:     cover property (@(posedge clk) disable iff (!reset_n) take && req_w8);
    c_boot:   cover property (@(posedge clk) disable iff (!reset_n) take && boot_active);
endmodule
`default_nettype wire

// ===== hdl/smrbm_timing_decode.sv
/*
 * Decodes one chip select's coded setup, pulse and cycle fields into counts.
 * Assumes the codes are stable while a read cycle runs.
 */
`default_nettype none
module smrbm_timing_decode
    import smrbm_pkg::*;
(
    input  wire logic [SETUP_W-1:0] rd_setup_code,
    input  wire logic [PULSE_W-1:0] rd_pulse_code,
    input  wire logic [SETUP_W-1:0] cs_setup_code,
    input  wire logic [PULSE_W-1:0] cs_pulse_code,
    input  wire logic [CYCLE_W-1:0] cycle_code,
    output logic      [CNT_W-1:0]   rd_setup,
    output logic      [CNT_W-1:0]   rd_pulse,
    output logic      [CNT_W-1:0]   cs_setup,
    output logic      [CNT_W-1:0]   cs_pulse,
    output logic      [CNT_W-1:0]   cycle
);
    assign rd_setup = (CNT_W'(rd_setup_code[5]) * SETUP_HI_MUL) + CNT_W'(rd_setup_code[4:0]);
    assign cs_setup = (CNT_W'(cs_setup_code[5]) * SETUP_HI_MUL) + CNT_W'(cs_setup_code[4:0]);
    assign rd_pulse = (CNT_W'(rd_pulse_code[6]) * PULSE_HI_MUL) + CNT_W'(rd_pulse_code[5:0]);
    assign cs_pulse = (CNT_W'(cs_pulse_code[6]) * PULSE_HI_MUL) + CNT_W'(cs_pulse_code[5:0]);
    assign cycle = (CNT_W'(cycle_code[8:7]) * CYCLE_HI_MUL) + CNT_W'(cycle_code[6:0]);
endmodule
`default_nettype wire
